// *** design/pos_selector.sv ***
// Top of the pulse output mode selector for four axes
`timescale 1ns/1ps
`default_nettype none
module pos_selector (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Selector switch pin and controller run state
  input wire logic form_sel_i,
  input wire logic ctrl_run_i,
  // Per-axis logical requests from the pulse generator
  input wire logic [3:0] pulse_req_i,
  input wire logic [3:0] dir_rev_i,
  input wire logic [3:0] clr_req_i,
  input wire logic [3:0] clr_redir_i,
  // Adapter differential outputs, bit n is output Yn
  output logic [7:0] primary_diff_terminal_o,
  output logic [7:0] complement_diff_terminal_o,
  // Main unit sink outputs, bit n is output Yn
  output logic [7:0] sink_level_o,
  // Separate clear outputs, logical level
  output logic [3:0] clr_out_o,
  // Form in force, high for forward/reverse
  output logic form_fwd_rev_o
);
  // All state of the top
  typedef struct packed {
    logic [1:0] sel_sync; // Two-stage synchroniser for the switch
    pos_pkg::pos_form_e form;
    logic [7:0] prim;
    logic [7:0] comp;
    logic [7:0] sink;
    logic [3:0] sink_dir; // Sink direction latched per train
    logic [3:0] clr;
  } pos_top_s;

  pos_top_s st_r;
  pos_top_s st_nxt;
  logic [3:0] busy;
  logic [3:0] prim_on;
  logic [3:0] sec_on;
  logic [3:0] clr_on;

  // Logical state to line level, negative logic
  function automatic logic to_level(input logic on);
    return on ? pos_pkg::LEVEL_ON : pos_pkg::LEVEL_OFF;
  endfunction

  // One stage per axis, adapter one holds axes 0-1, two holds 2-3
  genvar g;
  generate
    for (g = 0; g < pos_pkg::AXES; g++) begin : g_axis
      pos_axis_if ifc ();
      assign ifc.form_fwd_rev = (st_r.form == pos_pkg::POS_FORM_FWD_REV);
      assign ifc.pulse = pulse_req_i[g] & ctrl_run_i;
      assign ifc.dir_rev = dir_rev_i[g];
      assign ifc.clr = clr_req_i[g];
      assign ifc.clr_redir = clr_redir_i[g];
      assign busy[g] = ifc.busy;
      assign prim_on[g] = ifc.prim_on;
      assign sec_on[g] = ifc.sec_on;
      assign clr_on[g] = ifc.clr_on;
      pos_axis u_axis (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .ax(ifc.axis)
      );
    end
  endgenerate

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    // Switch pin is asynchronous, so it is synchronised first
    st_nxt.sel_sync = {st_r.sel_sync[0], form_sel_i};
    // Adopt a new form only with every axis idle; a running train
    // keeps its form even if the operator moves the switch
    if (busy == 4'h0) begin
      st_nxt.form = (st_r.sel_sync[1] == pos_pkg::SEL_FWD_REV) ?
        pos_pkg::POS_FORM_FWD_REV : pos_pkg::POS_FORM_PULSE_DIR;
    end
    for (int i = 0; i < pos_pkg::AXES; i++) begin
      // Pulse on Yi, direction or reverse on Y(i+4)
      st_nxt.prim[i] = to_level(prim_on[i]);
      st_nxt.prim[i + 4] = to_level(sec_on[i]);
      // Complement terminal is the inverse of the reference
      st_nxt.comp[i] = ~to_level(prim_on[i]);
      st_nxt.comp[i + 4] = ~to_level(sec_on[i]);
      // Sink outputs fixed to pulse plus direction
      st_nxt.sink[i] = to_level(pulse_req_i[i] & ctrl_run_i & busy[i]);
      // Direction latched on the last idle cycle and held while busy;
      // the level input alone could flip mid-train
      st_nxt.sink_dir[i] = busy[i] ? st_r.sink_dir[i] : dir_rev_i[i];
      st_nxt.sink[i + 4] = to_level(
        (busy[i] ? st_r.sink_dir[i] : dir_rev_i[i]) |
        (clr_req_i[i] & ~clr_redir_i[i]));
    end
    st_nxt.clr = clr_on; // Separate clear device
    if (reset_i) begin
      // Every line off: high level on reference and sink pins
      st_nxt.sel_sync = {2{pos_pkg::SEL_PULSE_PLUS_DIRECTION_MODE}};
      st_nxt.form = pos_pkg::POS_FORM_PULSE_DIR;
      st_nxt.prim = {8{pos_pkg::LEVEL_OFF}};
      st_nxt.comp = {8{pos_pkg::LEVEL_ON}};
      st_nxt.sink = {8{pos_pkg::LEVEL_OFF}};
      st_nxt.sink_dir = {4{pos_pkg::OUT_OFF}};
      st_nxt.clr = {4{pos_pkg::OUT_OFF}};
    end
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    st_r <= st_nxt;
  end

  // Outputs straight from flip-flops
  assign primary_diff_terminal_o = st_r.prim;
  assign complement_diff_terminal_o = st_r.comp;
  assign sink_level_o = st_r.sink;
  assign clr_out_o = st_r.clr;
  // Form flag is the one-bit enum register itself, no decode after it
  assign form_fwd_rev_o = logic'(st_r.form);

  // Form never changes while an axis is busy
  AST_FORM_FROZEN: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (busy != 4'h0) |=> $stable(st_r.form))
    else $error("form changed during a pulse train");

  // Terminals always complementary
  AST_COMPLEMENT: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    st_r.comp == ~st_r.prim)
    else $error("terminals not complementary");

  // Forward/reverse: never both outputs on for an axis; the form
  // reaches the pins two registers late, hence three cycles in force
  AST_FR_EXCL: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (st_r.form == pos_pkg::POS_FORM_FWD_REV) [*3] |->
      ((st_r.prim[3:0] | st_r.prim[7:4]) == 4'hF))
    else $error("forward and reverse both active");

  // Idle axes hold pulse lines at off level
  AST_IDLE_OFF: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (busy == 4'h0) ##1 (busy == 4'h0) |=> (st_r.prim[3:0] == 4'hF))
    else $error("pulse line active while idle");

  // Idle selector follows the synchronised switch on the next edge
  AST_FORM_FOLLOW: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (busy == 4'h0 && st_r.sel_sync[1] == pos_pkg::SEL_FWD_REV)
      |=> (busy != 4'h0) || (st_r.form == pos_pkg::POS_FORM_FWD_REV))
    else $error("form not adopted while idle");

  // Separate clear output follows axis clear with redirect
  AST_CLR_SEP: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (clr_req_i[2] && clr_redir_i[2]) |=> ##1 st_r.clr[2])
    else $error("redirected clear missing");

  // Sink direction carries clear when not redirected
  AST_SINK_CLR: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (clr_req_i[2] && !clr_redir_i[2]) |=> !st_r.sink[6])
    else $error("shared clear missing on sink direction");

  // Stopped controller gives no pulses
  AST_STOP_SAFE: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (!ctrl_run_i) [*3] |=> (st_r.sink[3:0] == 4'hF))
    else $error("pulse while stopped");

  // Sink direction latch is frozen for every busy axis
  AST_SINK_DIR_HELD: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (busy != 4'h0) |=>
      (((st_r.sink_dir ^ $past(st_r.sink_dir)) & $past(busy)) == 4'h0))
    else $error("sink direction moved during a train");

  // Axis 0 leaving idle
  sequence seq_axis0_rise;
    !busy[0] ##1 busy[0];
  endsequence

  // Sink pulse never leads the latched direction
  AST_SINK_SETTLE: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    seq_axis0_rise |-> (st_r.sink[0] == pos_pkg::LEVEL_OFF))
    else $error("sink pulse before direction latched");

  // Pulse plus direction: adapter pulse waits two more cycles
  AST_PD_PRIM_LATE: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    seq_axis0_rise ##0 (st_r.form == pos_pkg::POS_FORM_PULSE_DIR) |=>
      (st_r.prim[0] == pos_pkg::LEVEL_OFF) [*2])
    else $error("adapter pulse before direction settled");

  // Idle axis 2, pulse plus direction, clear left on the shared pin
  sequence seq_ax2_shared_clr;
    (st_r.form == pos_pkg::POS_FORM_PULSE_DIR) && !busy[2] &&
      clr_req_i[2] && !clr_redir_i[2];
  endsequence

  // Shared clear reaches the adapter direction line two cycles on
  AST_ADP_CLR: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    seq_ax2_shared_clr |=> ##1 (st_r.prim[6] == pos_pkg::LEVEL_ON))
    else $error("shared clear missing on adapter direction");
endmodule
`default_nettype wire

// *** inc/pos_pkg.sv ***
// Package of constants and types for the pulse output mode selector
package pos_pkg;
  // Number of axes served
  localparam int unsigned AXES = 4;
  // Axes per adapter
  localparam int unsigned AXES_PER_ADAPTER = 2;
  // Reset value of each logical output (off)
  localparam logic OUT_OFF = 1'b0;
  // Electrical level of an on output (negative logic: low)
  localparam logic LEVEL_ON = 1'b0;
  // Electrical level of an off output
  localparam logic LEVEL_OFF = 1'b1;
  // Selector encoding: 0 pulse plus direction, 1 forward/reverse
  localparam logic SEL_PULSE_PLUS_DIRECTION_MODE = 1'b0;
  localparam logic SEL_FWD_REV = 1'b1;
  // Output form in force
  typedef enum logic {
    POS_FORM_PULSE_DIR,
    POS_FORM_FWD_REV
  } pos_form_e;
  // Per-axis run state
  typedef enum logic [1:0] {
    POS_ST_IDLE,
    POS_ST_SETTLE,
    POS_ST_RUN
  } pos_state_e;
endpackage

// *** inc/pos_axis_if.sv ***
// Interface between the top and one axis output stage
`timescale 1ns/1ps
`default_nettype none
interface pos_axis_if;
  logic form_fwd_rev; // Form in force, high for forward/reverse
  logic busy;         // Pulse train in progress on this axis
  logic pulse;        // Logical pulse request, high for on
  logic dir_rev;      // Requested direction, high for reverse
  logic clr;          // Homing clear request, logical on
  logic clr_redir;    // Clear moved to separate output
  logic prim_on;      // Logical state of primary output
  logic sec_on;       // Logical state of secondary output
  logic clr_on;       // Logical state of separate clear output
  modport top (output form_fwd_rev, output pulse, output dir_rev,
    output clr, output clr_redir, input busy, input prim_on,
    input sec_on, input clr_on);
  modport axis (input form_fwd_rev, input pulse, input dir_rev,
    input clr, input clr_redir, output busy, output prim_on,
    output sec_on, output clr_on);
endinterface
`default_nettype wire

// *** design/pos_axis.sv ***
// One axis output stage: form mapping and direction hold
`timescale 1ns/1ps
`default_nettype none
module pos_axis (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // Control from the selector top
  pos_axis_if.axis ax
);
  // All state of one axis
  typedef struct packed {
    pos_pkg::pos_state_e st;
    logic dir;   // Direction latched for the train
    logic prim;
    logic sec;
    logic clr;
  } pos_axis_s;

  pos_axis_s st_r;
  pos_axis_s st_nxt;

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.prim = pos_pkg::OUT_OFF;
    st_nxt.sec = pos_pkg::OUT_OFF;
    unique case (st_r.st)
      pos_pkg::POS_ST_IDLE: begin
        // Latch direction before any pulse leaves
        st_nxt.dir = ax.dir_rev;
        if (ax.pulse) begin
          st_nxt.st = pos_pkg::POS_ST_SETTLE;
        end
      end
      pos_pkg::POS_ST_SETTLE: begin
        // One cycle of settled direction ahead of the first edge in pulse plus direction form
        st_nxt.st = pos_pkg::POS_ST_RUN;
      end
      pos_pkg::POS_ST_RUN: begin
        if (!ax.pulse) begin
          st_nxt.st = pos_pkg::POS_ST_IDLE;
        end
      end
      default: begin
        // Unused fourth code of the state falls back to idle
        st_nxt.st = pos_pkg::POS_ST_IDLE;
      end
    endcase
    if (st_r.st != pos_pkg::POS_ST_IDLE) begin
      if (ax.form_fwd_rev) begin
        // Forward on primary, reverse on secondary
        st_nxt.prim = ax.pulse & ~st_r.dir;
        st_nxt.sec = ax.pulse & st_r.dir;
      end else begin
        // Pulse plus held direction level
        st_nxt.prim = ax.pulse & (st_r.st == pos_pkg::POS_ST_RUN);
        st_nxt.sec = st_r.dir;
      end
    end else if (!ax.form_fwd_rev) begin
      // Direction output idles at requested level, or carries clear
      st_nxt.sec = ax.clr_redir ? st_nxt.dir : (st_nxt.dir | ax.clr);
    end
    // Clear shares direction pin unless moved
    st_nxt.clr = ax.clr & ax.clr_redir;
    if (reset_i) begin
      st_nxt.st = pos_pkg::POS_ST_IDLE;
      st_nxt.dir = pos_pkg::OUT_OFF;
      st_nxt.prim = pos_pkg::OUT_OFF;
      st_nxt.sec = pos_pkg::OUT_OFF;
      st_nxt.clr = pos_pkg::OUT_OFF;
    end
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    st_r <= st_nxt;
  end

  assign ax.busy = (st_r.st != pos_pkg::POS_ST_IDLE);
  assign ax.prim_on = st_r.prim;
  assign ax.sec_on = st_r.sec;
  assign ax.clr_on = st_r.clr;

  // Direction stays fixed while a train runs
  AST_DIR_HELD: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (st_r.st == pos_pkg::POS_ST_RUN) |=> $stable(st_r.dir))
    else $error("direction changed during train");

  // No pulse on primary in the settle cycle in pulse plus direction form
  AST_SETTLE_FIRST: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (st_r.st == pos_pkg::POS_ST_SETTLE && !ax.form_fwd_rev)
      |=> !st_r.prim)
    else $error("pulse before direction settled");
endmodule
`default_nettype wire

// *** testbench/pos_servo_model.sv ***
// Servo amplifier command pulse input model counting command pulses
`timescale 1ns/1ps
`default_nettype none
module pos_servo_model (
  // Clock
  input wire logic core_clk_i,
  // Reference terminal levels of the pulse and sign lines
  input wire logic pulse_n_i,
  input wire logic sign_n_i,
  // Configured input form, high for forward/reverse
  input wire logic fwd_rev_i,
  // Pulses counted per direction
  output logic [7:0] fwd_cnt_o,
  output logic [7:0] rev_cnt_o
);
  logic [7:0] fwd_cnt = 8'h00; // Forward command pulses seen
  logic [7:0] rev_cnt = 8'h00; // Reverse command pulses seen
  logic pulse_q = 1'b1; // Last pulse line level, idle high
  logic sign_q = 1'b1; // Last sign line level, idle high
  assign fwd_cnt_o = fwd_cnt;
  assign rev_cnt_o = rev_cnt;
  // Low-going edge is a command pulse, since the lines are active low
  always @(posedge core_clk_i) begin
    if (pulse_q && !pulse_n_i) begin
      // Sign low means reverse in pulse plus sign form
      if (!fwd_rev_i && !sign_n_i) begin
        rev_cnt <= rev_cnt + 8'h01;
      end else begin
        fwd_cnt <= fwd_cnt + 8'h01;
      end
    end
    // Second line carries reverse pulses in forward/reverse form
    if (fwd_rev_i && sign_q && !sign_n_i) begin
      rev_cnt <= rev_cnt + 8'h01;
    end
    pulse_q <= pulse_n_i;
    sign_q <= sign_n_i;
  end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the pulse output mode selector
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0; // 20 MHz core clock
  logic reset = 1'b1; // Held for six cycles
  logic form_sel = 1'b0; // Switch pin, starts in pulse plus direction
  logic ctrl_run = 1'b1; // Controller running
  logic [3:0] pulse_req = 4'h0;
  logic [3:0] dir_rev = 4'h0;
  logic [3:0] clr_req = 4'h0;
  logic [3:0] clr_redir = 4'h0;
  logic [7:0] prim, comp, sink; // Terminal and sink levels
  logic [3:0] clr_out;
  logic form_fr;
  logic [7:0] fwd_cnt, rev_cnt; // Counts seen by the amplifier
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #25 core_clk = ~core_clk;
  pos_selector dut (.core_clk_i(core_clk), .reset_i(reset),
    .form_sel_i(form_sel), .ctrl_run_i(ctrl_run),
    .pulse_req_i(pulse_req), .dir_rev_i(dir_rev), .clr_req_i(clr_req),
    .clr_redir_i(clr_redir), .primary_diff_terminal_o(prim),
    .complement_diff_terminal_o(comp), .sink_level_o(sink),
    .clr_out_o(clr_out), .form_fwd_rev_o(form_fr));
  // Amplifier wired to axis one, configured like the switch
  pos_servo_model servo (.core_clk_i(core_clk), .pulse_n_i(prim[0]),
    .sign_n_i(prim[4]), .fwd_rev_i(form_sel), .fwd_cnt_o(fwd_cnt),
    .rev_cnt_o(rev_cnt));
  // Inputs move on the falling edge, away from sampling
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Compare and report
  task automatic chk(input string what, input logic [7:0] exp,
    input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Closing report
  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Hang guard, well above the 76 cycles used
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_errors++;
      test_done();
    end
  end
  // Reset levels: all outputs off, so reference and sink lines high, complement low
  task automatic t_reset;
    chk("reset primary", 8'hFF, prim);
    chk("reset complement", 8'h00, comp);
    chk("reset sink", 8'hFF, sink);
    chk("reset form", 8'h00, {7'h0, form_fr});
  endtask
  // Reverse move in pulse plus direction, direction change mid-train
  task automatic t_pulse_dir;
    logic [7:0] r0;
    r0 = rev_cnt;
    dir_rev = 4'h1;
    pulse_req = 4'h1;
    cyc(4);
    chk("pd primary", 8'hEE, prim);
    chk("pd complement", 8'h11, comp);
    chk("pd sink", 8'hEE, sink);
    dir_rev = 4'h0;
    cyc(3);
    chk("pd direction held", 8'hEE, prim);
    chk("pd sink direction held", 8'hEE, sink);
    pulse_req = 4'h0;
    cyc(4);
    chk("pd reverse count", r0 + 8'h01, rev_cnt);
  endtask
  // Stopped controller gates pulses; switch is moved while stopped
  task automatic t_stop_switch;
    ctrl_run = 1'b0;
    pulse_req = 4'h2;
    form_sel = 1'b1;
    cyc(6);
    chk("stop primary", 8'hFF, prim);
    chk("stop form", 8'h01, {7'h0, form_fr});
    pulse_req = 4'h0;
    ctrl_run = 1'b1;
    cyc(2);
  endtask
  // Forward/reverse form: reverse on second line, sink stays pulse+dir
  task automatic t_fwd_rev;
    logic [7:0] f0;
    logic [7:0] r0;
    dir_rev = 4'h2;
    pulse_req = 4'h2;
    cyc(4);
    chk("fr axis two", 8'hDF, prim);
    chk("fr sink", 8'hDD, sink);
    pulse_req = 4'h0;
    cyc(4);
    f0 = fwd_cnt;
    r0 = rev_cnt;
    dir_rev = 4'h0;
    pulse_req = 4'h1;
    cyc(4);
    chk("fr forward", 8'hFE, prim);
    pulse_req = 4'h0;
    cyc(4);
    dir_rev = 4'h1;
    pulse_req = 4'h1;
    cyc(4);
    chk("fr reverse", 8'hEF, prim);
    pulse_req = 4'h0;
    cyc(4);
    chk("fr fwd count", f0 + 8'h01, fwd_cnt);
    chk("fr rev count", r0 + 8'h01, rev_cnt);
  endtask
  // Switch moved during a train takes effect only once idle
  task automatic t_busy_switch;
    dir_rev = 4'h0;
    pulse_req = 4'h8;
    cyc(3);
    form_sel = 1'b0;
    cyc(6);
    chk("busy form", 8'h01, {7'h0, form_fr});
    chk("busy primary", 8'hF7, prim);
    pulse_req = 4'h0;
    cyc(8);
    chk("idle form", 8'h00, {7'h0, form_fr});
  endtask
  // Clear shares the direction line unless moved to its own output
  task automatic t_clear;
    clr_req = 4'h4;
    cyc(4);
    chk("shared clear", 8'hBF, prim);
    chk("shared clear sink", 8'hBF, sink);
    chk("no own clear", 8'h00, {4'h0, clr_out});
    clr_redir = 4'h4;
    cyc(4);
    chk("own clear", 8'h04, {4'h0, clr_out});
    chk("line free", 8'hFF, prim);
    chk("sink line free", 8'hFF, sink);
    clr_req = 4'h0;
    clr_redir = 4'h0;
  endtask
  // Main sequence
  initial begin
    cyc(6);
    t_reset();
    reset = 1'b0;
    cyc(2);
    t_pulse_dir();
    t_stop_switch();
    t_fwd_rev();
    t_busy_switch();
    t_clear();
    test_done();
  end
endmodule
`default_nettype wire
